// File: pcm_and_control_serial_port_tb.sv
// pcm_and_control_serial_port_tb.sv: self-checking bench for pcs_port.
// assumes pcs_defs.vh, the checker and the dsp model are compiled.
`include "pcs_defs.vh"
module pcm_and_control_serial_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock_in, rst_in, ctrl_clk, ctrl_sel_n, ctrl_si, button_in, pwr;
   logic [13:0] voice_tx;
   wire link_clk, frame_sync, pcm_rx, pcm_tx, pcm_tx_oe, ctrl_so;
   wire button_out, power_down, rx_valid, rx_inj, ctrl_oe;
   wire [13:0] voice_rx;
   wire [7:0] cfg_a, cfg_b, rx_path;
   wire [15:0] tx_bits, n_bits;
   wire [4:0] slot_start;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   int rx_words = 0;
   pcs_port #(.DEB_CYCLES(20)) i_pcs_port (
      .clock_in(clock_in), .rst_in(rst_in), .link_clk_in(link_clk),
      .frame_sync_in(frame_sync), .pcm_rx_in(pcm_rx),
      .pcm_tx_out(pcm_tx), .pcm_tx_oe_out(pcm_tx_oe),
      .voice_tx_in(voice_tx), .voice_rx_out(voice_rx),
      .voice_rx_valid_out(rx_valid),
      .rx_path_out(rx_path), .rx_path_inject_out(rx_inj),
      .ctrl_clk_in(ctrl_clk), .ctrl_sel_n_in(ctrl_sel_n),
      .ctrl_serial_in(ctrl_si), .ctrl_serial_out(ctrl_so),
      .ctrl_serial_oe_out(ctrl_oe), .power_down_out(power_down),
      .config_reg_a_out(cfg_a), .config_reg_b_out(cfg_b),
      .button_in(button_in), .button_out(button_out));
   pcs_dsp_model i_pcs_dsp_model (
      .rx_byte_in(8'h96), .pcm_tx_in(pcm_tx), .pcm_tx_oe_in(pcm_tx_oe),
      .link_clk_out(link_clk), .frame_sync_out(frame_sync),
      .pcm_rx_out(pcm_rx), .tx_bits_out(tx_bits),
      .slot_start_out(slot_start), .n_bits_out(n_bits));
   initial begin
      clock_in = 0;
      forever #25 clock_in = ~clock_in;
   end
   task conclude;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (rx_valid)
         rx_words <= rx_words + 1;
      if (cyc == 40000) begin
         err_total++;
         conclude();
      end
   end
   task chk(input string nm, input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task tick(input int n);
      repeat (n) @(negedge clock_in);
   endtask
   // eight clocks a byte, msb first, read on rise
   task xfer(input logic [7:0] b, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         ctrl_clk = 0;
         ctrl_si = b[i];
         tick(6);
         ctrl_clk = 1;
         r[i] = ctrl_so;
         tick(6);
      end
   endtask
   task cs_lo;
      ctrl_sel_n = 0;
      tick(6);
   endtask
   task cs_hi;
      ctrl_clk = 0;
      tick(6);
      ctrl_sel_n = 1;
      tick(10);
   endtask
   task wr(input logic [3:0] a, input logic [7:0] d, input logic split);
      logic [7:0] r;
      cs_lo();
      xfer({pwr, a, 3'h2}, r);
      if (split) begin
         cs_hi();
         cs_lo();
      end
      xfer(d, r);
      cs_hi();
   endtask
   task rd(input logic [3:0] a, output logic [7:0] r);
      cs_lo();
      xfer({pwr, a, 3'h6}, r);
      xfer(8'h00, r);
      cs_hi();
   endtask
   task frames(input int n);
      repeat (n) @(posedge frame_sync);
      repeat (20) @(posedge link_clk);
      tick(1);
   endtask
   task t_regs;
      logic [7:0] r;
      chk("pd_reset", power_down, 1);
      chk("tx_oe_reset", pcm_tx_oe, 0);
      wr(`PCS_ADR_CFG_A, 8'h24, 1);
      chk("cfg_a", cfg_a, 8'h24);
      wr(`PCS_ADR_CFG_B, 8'h84, 0);
      chk("cfg_b", cfg_b, 8'h84);
      rd(`PCS_ADR_CFG_B, r);
      chk("rd_b", r, 8'h84);
      rd(4'h5, r);
      chk("rd_unmapped", r, 8'h00);
      chk("co_float", ctrl_oe, 0);
      cs_lo();
      xfer(8'h00, r);
      cs_hi();
      chk("pd_single", power_down, 0);
      pwr = 0;
   endtask
   task slot(input logic [7:0] a, b, input logic [4:0] s);
      wr(`PCS_ADR_CFG_A, a, 0);
      wr(`PCS_ADR_CFG_B, b, 0);
      frames(2);
      chk("slot_start", slot_start, s);
      chk("slot_data", tx_bits[7:0], voice_tx[7:0]);
   endtask
   task t_pcm;
      logic [7:0] r;
      logic [15:0] n;
      int w;
      slot(8'h20, 8'h86, 5'h08);
      slot(8'h24, 8'h86, 5'h0a);
      slot(8'h00, 8'h86, 5'h00);
      chk("linear", tx_bits[13:0], voice_tx);
      slot(8'h20, 8'h84, 5'h00);
      wr(`PCS_ADR_TX_INJ, 8'h3c, 0);
      frames(1);
      chk("inject", tx_bits[7:0], 8'h3c);
      frames(1);
      chk("inject_once", tx_bits[7:0], voice_tx[7:0]);
      rd(`PCS_ADR_RX_INJ, r);
      chk("rx_byte", r, 8'h96);
      chk("voice_rx", voice_rx[7:0], 8'h96);
      chk("rx_path_dr", rx_path, 8'h96);
      wr(`PCS_ADR_RX_INJ, 8'h71, 0);
      wr(`PCS_ADR_CFG_B, 8'h94, 0);
      chk("rx_path", rx_path, 8'h71);
      chk("rx_src", rx_inj, 1);
      // m[1]: reverse else delayed; m[0]: voice on, else aux or off
      for (int m = 0; m < 4; m++) begin
         wr(`PCS_ADR_CFG_B, {m[1], 4'h8, m[0], 1'b0, ~m[0] & ~m[1]}, 0);
         frames(1);
         n = n_bits;
         w = rx_words;
         frames(2);
         chk("slot_bits", n_bits - n, m[0] ? 16 : 0);
         chk("rx_words", rx_words - w, m[0] ? 2 : 0);
         if (m[0])
            chk("mode_data", tx_bits[7:0], voice_tx[7:0]);
      end
   endtask
   task btn(input logic lvl, input logic exp);
      button_in = lvl;
      tick(60);
      chk("button", button_out, exp);
   endtask
   task t_button;
      pwr = 1;
      wr(`PCS_ADR_BUTTON, 8'h00, 0);
      chk("pd_cmd", power_down, 1);
      btn(0, 0);
      wr(`PCS_ADR_BUTTON, 8'h80, 0);
      btn(0, 1);
      btn(1, 0);
      wr(`PCS_ADR_BUTTON, 8'ha0, 0);
      btn(0, 0);
      btn(1, 1);
      wr(`PCS_ADR_BUTTON, 8'hc0, 0);
      btn(0, 1);
      btn(1, 1);
      wr(`PCS_ADR_BUTTON, 8'hc0, 0);
      chk("latch_clear", button_out, 0);
   endtask
   initial begin
      rst_in = 1;
      ctrl_clk = 0;
      ctrl_sel_n = 1;
      ctrl_si = 0;
      button_in = 1;
      pwr = 1;
      voice_tx = 14'h2a5c;
      tick(20);
      rst_in = 0;
      tick(5);
      t_regs();
      t_pcm();
      t_button();
      conclude();
   end
endmodule // pcm_and_control_serial_port_tb
bind pcs_port pcs_port_checker #(.DEB_CYCLES(DEB_CYCLES)) i_pcs_port_checker (
   .clock_in(clock_in), .rst_in(rst_in), .link_clk_in(link_clk_in),
   .pcm_tx_out(pcm_tx_out), .pcm_tx_oe_out(pcm_tx_oe_out),
   .ctrl_sel_n_in(ctrl_sel_n_in), .ctrl_serial_oe_out(ctrl_serial_oe_out),
   .power_down_out(power_down_out), .config_reg_a_out(config_reg_a_out),
   .config_reg_b_out(config_reg_b_out));

// File: pcs_debounce.v
// pcs_debounce.v: button debouncer; output changes once the input
// has been stable for the full count. input already synchronised.
`include "pcs_defs.vh"
module pcs_debounce #(
   parameter DEB_CYCLES = `PCS_DEB_CYCLES
) (
   input wire clock_in,
   input wire rst_in,
   input wire run_in,
   input wire level_in,
   output reg level_out
);
   reg [20:0] cnt_r;
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_r <= 21'h00_0000;
         level_out <= 1'b1;
      end else if (!run_in) begin
         cnt_r <= 21'h00_0000;
         level_out <= 1'b1;
      end else if (level_in == level_out) begin
         cnt_r <= 21'h00_0000;
      end else if (cnt_r >= DEB_CYCLES[20:0] - 21'h00_0001) begin
         cnt_r <= 21'h00_0000;
         level_out <= level_in;
      end else begin
         cnt_r <= cnt_r + 21'h00_0001;
      end
   end
endmodule // pcs_debounce

// File: pcs_defs.vh
// pcs_defs.vh: constants for the pcm and control serial port.
// assumes a 20 MHz system clock; all pin inputs are oversampled.
`ifndef PCS_DEFS_VH
`define PCS_DEFS_VH
// first control byte fields
`define PCS_CMD_POWER_BIT 7
`define PCS_CMD_READ_BIT 2
`define PCS_CMD_MORE_BIT 1
`define PCS_CMD_ADDR_HI 6
`define PCS_CMD_ADDR_LO 3
// register addresses (bits 6..3 of the first byte)
`define PCS_ADR_CFG_A 4'h0
`define PCS_ADR_CFG_B 4'h1
`define PCS_ADR_RX_INJ 4'h2
`define PCS_ADR_TX_INJ 4'h3
`define PCS_ADR_BUTTON 4'ha
// config_reg_a fields
`define PCS_A_FREQ_HI 7
`define PCS_A_FREQ_LO 6
`define PCS_A_CODE_SEL 5
`define PCS_A_FMT_SEL 2
// config_reg_b fields
`define PCS_B_MODE_HI 7
`define PCS_B_MODE_LO 6
`define PCS_B_VOICE_EN 2
`define PCS_B_RX_SRC 4
`define PCS_B_SLOT_CH 1
`define PCS_B_CLK_SRC 0
// button_ctrl_reg fields
`define PCS_BT_ENABLE 7
`define PCS_BT_LATCH_MODE 6
`define PCS_BT_INVERT 5
`define PCS_BT_LATCHED 4
// reset values
`define PCS_RST_CFG_A 8'h00
`define PCS_RST_CFG_B 8'h00
`define PCS_RST_BUTTON 8'h00
// slot geometry in link clock cycles
`define PCS_SLOT_BITS 6'h08
`define PCS_LIN_BITS 6'h0e
`define PCS_FMT2_GAP 6'h02
// debounce: 50 ms at 20 MHz, an exact count, no rounding
`define PCS_DEB_MS 50
`define PCS_CLK_KHZ 20000
`define PCS_DEB_CYCLES (`PCS_DEB_MS * `PCS_CLK_KHZ)
`endif

// File: pcs_dsp_model.sv
// pcs_dsp_model.sv: baseband side of the pcm port.
// assumes 32 link clocks a frame, slot bits counted from sync rise.
module pcs_dsp_model (
   input wire logic [7:0] rx_byte_in,
   input wire logic pcm_tx_in,
   input wire logic pcm_tx_oe_in,
   output logic link_clk_out,
   output logic frame_sync_out,
   output logic pcm_rx_out,
   output logic [15:0] tx_bits_out,
   output logic [4:0] slot_start_out,
   output logic [15:0] n_bits_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] idx;
   logic was_oe;
   wire [4:0] nxt = (idx == 5'h1f) ? 5'h00 : idx + 5'h01;
   initial begin
      link_clk_out = 0;
      frame_sync_out = 0;
      pcm_rx_out = 1;
      tx_bits_out = 0;
      slot_start_out = 0;
      n_bits_out = 0;
      idx = 0;
      was_oe = 0;
      #13;
      // master clock runs free, phase unrelated to clock_in
      forever #200 link_clk_out = ~link_clk_out;
   end
   always @(posedge link_clk_out) begin
      frame_sync_out <= (nxt == 5'h00);
      // idle data toggles so a stale bit never looks valid
      pcm_rx_out <= (nxt < 5'h08) ? rx_byte_in[3'h7 - nxt[2:0]]
                                  : ~pcm_rx_out;
      // bit launched last rise is sampled a full period later
      if (pcm_tx_oe_in) begin
         tx_bits_out <= {tx_bits_out[14:0], pcm_tx_in};
         n_bits_out <= n_bits_out + 16'h0001;
         if (!was_oe) begin
            slot_start_out <= idx;
         end
      end
      was_oe <= pcm_tx_oe_in;
      idx <= nxt;
   end
endmodule // pcs_dsp_model

// File: pcs_port.v
// pcs_port.v: pcm voice port, serial control port, injection paths
// and headset button detector. link clock, frame sync, control pins
// and button pin all come from outside and are oversampled by
// clock_in, which must be at least 4x the fastest link clock.
// Functional notes
// - frame sync of any width; only its rising edge is used.
// - long frame: first slot starts at the frame sync rising edge.
// - mode bits: hi 0 delayed, 10 normal, 11 reverse.
// - linear coding sends and takes the msb first.
// - slot choice only applies with companded coding.
// - format 1: slot one 8 clocks after sync, slot two next 8.
// - format 2: slot two starts two bits after slot one ends.
// - format from config a bit 2, slot from config b bit 1.
// - config b bit 2 gates voice drive and capture.
// - tx shifts on rising edges, on falling in reverse mode.
// - rx sampled on falling edges, on rising in reverse mode.
// - tx pin undriven outside the assigned slot.
// - control byte is 8 clocks with select low, sampled rising.
// - first byte decoded; second byte loads register, any cs form.
// - bit 1 announces second byte, bit 2 read; else power only.
// - bit 7 of first byte: 1 power down, 0 power up.
// - control bytes shifted msb first both directions.
// - read: 8 more clocks, device drives on falling edges.
// - control output undriven while select is high.
// - tx inject byte sent in chosen slot of next companded frame.
// - rx inject feeds receive path; read returns last rx byte.
// - aux clock selected: pcm port idle.
// - button detector runs when enabled, even in power down.
// - transparent or latched button indication, 50 ms debounce.
// - invert bit flips button output polarity.
`include "pcs_defs.vh"
module pcs_port #(
   parameter DEB_CYCLES = `PCS_DEB_CYCLES
) (
   input wire clock_in,
   input wire rst_in,
   input wire link_clk_in,
   input wire frame_sync_in,
   input wire pcm_rx_in,
   output reg pcm_tx_out,
   output reg pcm_tx_oe_out,
   input wire [13:0] voice_tx_in,
   output reg [13:0] voice_rx_out,
   output reg voice_rx_valid_out,
   output reg [7:0] rx_path_out,
   output reg rx_path_inject_out,
   input wire ctrl_clk_in,
   input wire ctrl_sel_n_in,
   input wire ctrl_serial_in,
   output reg ctrl_serial_out,
   output reg ctrl_serial_oe_out,
   output reg power_down_out,
   output reg [7:0] config_reg_a_out,
   output reg [7:0] config_reg_b_out,
   input wire button_in,
   output reg button_out
);
   localparam ST_CMD = 3'b001;
   localparam ST_WDATA = 3'b010;
   localparam ST_RDATA = 3'b100;

   wire lclk_s, fs_s, rx_s, ctrl_clk_s, csn_s, ci_s, btn_s;
   pcs_sync u_s0 (.clock_in(clock_in), .rst_in(rst_in),
      .d_in(link_clk_in), .q_out(lclk_s));
   pcs_sync u_s1 (.clock_in(clock_in), .rst_in(rst_in),
      .d_in(frame_sync_in), .q_out(fs_s));
   pcs_sync u_s2 (.clock_in(clock_in), .rst_in(rst_in),
      .d_in(pcm_rx_in), .q_out(rx_s));
   pcs_sync u_s3 (.clock_in(clock_in), .rst_in(rst_in),
      .d_in(ctrl_clk_in), .q_out(ctrl_clk_s));
   pcs_sync u_s4 (.clock_in(clock_in), .rst_in(rst_in),
      .d_in(ctrl_sel_n_in), .q_out(csn_s));
   pcs_sync u_s5 (.clock_in(clock_in), .rst_in(rst_in),
      .d_in(ctrl_serial_in), .q_out(ci_s));
   pcs_sync u_s6 (.clock_in(clock_in), .rst_in(rst_in),
      .d_in(button_in), .q_out(btn_s));

   reg lclk_d_r, fs_d_r, ctrl_clk_d_r;
   reg fs_seen_r;
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         lclk_d_r <= 1'b0;
         fs_d_r <= 1'b0;
         ctrl_clk_d_r <= 1'b0;
      end else begin
         lclk_d_r <= lclk_s;
         fs_d_r <= fs_s;
         ctrl_clk_d_r <= ctrl_clk_s;
      end
   end
   wire lclk_rise = lclk_s & ~lclk_d_r;
   wire lclk_fall = ~lclk_s & lclk_d_r;
   wire ctrl_clk_rise = ctrl_clk_s & ~ctrl_clk_d_r;
   wire ctrl_clk_fall = ~ctrl_clk_s & ctrl_clk_d_r;

   // configuration fields
   reg [7:0] inj_tx_r, inj_rx_r, rx_last_r, button_reg_r;
   reg inj_tx_pend_r, wr_tx_inj;
   wire companded = config_reg_a_out[`PCS_A_CODE_SEL];
   wire fmt_two = config_reg_a_out[`PCS_A_FMT_SEL];
   wire mode_hi = config_reg_b_out[`PCS_B_MODE_HI];
   wire mode_lo = config_reg_b_out[`PCS_B_MODE_LO];
   wire voice_en = config_reg_b_out[`PCS_B_VOICE_EN];
   wire aux_sel = config_reg_b_out[`PCS_B_CLK_SRC];
   // reverse only with both mode bits set
   wire reverse = mode_hi & mode_lo;
   wire tx_edge = reverse ? lclk_fall : lclk_rise;
   wire rx_edge = reverse ? lclk_rise : lclk_fall;
   // aux clock keeps the pcm port idle
   wire pcm_on = voice_en & ~aux_sel & ~power_down_out;

   // only the sync edge is used; width is irrelevant
   // long frame starts on the sync edge; short frame on
   // the first link rising edge after the sync rising edge.
   reg [5:0] bit_r;
   reg in_frame_r;
   wire fs_edge = fs_s & ~fs_d_r;
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         fs_seen_r <= 1'b0;
      end else if (fs_edge) begin
         fs_seen_r <= 1'b1;
      end else if (lclk_rise) begin
         fs_seen_r <= 1'b0;
      end
   end
   wire frame_go = mode_hi ? fs_edge : (lclk_rise & fs_seen_r);

   // slot window in bit periods counted from frame start
   function [5:0] slot_start;
      input comp, fmt2, two;
      begin
         if (!comp || !two)
            slot_start = 6'h00;
         // gap of two bits for the d channel
         else if (fmt2)
            slot_start = `PCS_SLOT_BITS + `PCS_FMT2_GAP;
         // slot two right after slot one
         else
            slot_start = `PCS_SLOT_BITS;
      end
   endfunction
   // slot choice only honoured with companded coding
   wire [5:0] s_beg = slot_start(companded, fmt_two,
      config_reg_b_out[`PCS_B_SLOT_CH]);
   // linear word is 14 bits, msb first
   wire [5:0] s_len = companded ? `PCS_SLOT_BITS : `PCS_LIN_BITS;
   wire in_slot = in_frame_r && bit_r >= s_beg && bit_r < s_beg + s_len;

   reg [13:0] tx_sh_r, rx_sh_r;
   reg [5:0] rx_cnt_r;
   // outside reverse mode a frame launches bit 0 on the very edge that opens it
   wire [13:0] tx_word = !companded ? voice_tx_in :
      inj_tx_pend_r ? {inj_tx_r, 6'h00} : {voice_tx_in[7:0], 6'h00};
   wire [13:0] tx_src = frame_go ? tx_word : tx_sh_r;
   // index of the bit that a launch edge puts on the pin
   wire [5:0] tx_idx = reverse ? bit_r : frame_go ? 6'h00 : bit_r + 6'h01;
   wire tx_slot = (frame_go | in_frame_r) && tx_idx >= s_beg &&
      tx_idx < s_beg + s_len;
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         bit_r <= 6'h00;
         in_frame_r <= 1'b0;
         tx_sh_r <= 14'h0000;
         rx_sh_r <= 14'h0000;
         rx_cnt_r <= 6'h00;
         pcm_tx_out <= 1'b0;
         pcm_tx_oe_out <= 1'b0;
         voice_rx_out <= 14'h0000;
         voice_rx_valid_out <= 1'b0;
         rx_last_r <= 8'h00;
         inj_tx_pend_r <= 1'b0;
      end else begin
         voice_rx_valid_out <= 1'b0;
         if (frame_go) begin
            bit_r <= 6'h00;
            in_frame_r <= 1'b1;
            rx_cnt_r <= 6'h00;
            tx_sh_r <= tx_word;
            // injected byte replaces voice in companded coding, spent by this frame only if companded
            if (companded)
               inj_tx_pend_r <= 1'b0;
         end else if (lclk_rise && in_frame_r) begin
            if (bit_r == 6'h3f)
               in_frame_r <= 1'b0;
            else
               bit_r <= bit_r + 6'h01;
         end
         if (wr_tx_inj)
            inj_tx_pend_r <= 1'b1;
         // tx driven only inside the assigned slot
         if (!pcm_on) begin
            pcm_tx_oe_out <= 1'b0;
         end else if (tx_edge) begin
            // enable moves on launch edges: last bit stands a period
            pcm_tx_oe_out <= tx_slot;
            if (tx_slot) begin
               pcm_tx_out <= tx_src[13];
               tx_sh_r <= {tx_src[12:0], 1'b0};
            end
         end
         if (pcm_on && in_slot && rx_edge && rx_cnt_r < s_len) begin
            rx_sh_r <= {rx_sh_r[12:0], rx_s};
            rx_cnt_r <= rx_cnt_r + 6'h01;
            if (rx_cnt_r == s_len - 6'h01) begin
               voice_rx_out <= {rx_sh_r[12:0], rx_s};
               voice_rx_valid_out <= 1'b1;
               // last received byte kept for read-back
               rx_last_r <= {rx_sh_r[6:0], rx_s};
            end
         end
      end
   end

   // control port
   reg [2:0] cst_r;
   reg [7:0] csh_r, cmd_r, rd_sh_r;
   reg [3:0] ccnt_r;
   wire [3:0] cadr = cmd_r[`PCS_CMD_ADDR_HI:`PCS_CMD_ADDR_LO];
   wire [7:0] cbyte = {csh_r[6:0], ci_s};
   wire [3:0] nadr = cbyte[`PCS_CMD_ADDR_HI:`PCS_CMD_ADDR_LO];

   function [7:0] rd_mux;
      input [3:0] a;
      input [7:0] ra, rb, rl, bt;
      begin
         case (a)
            `PCS_ADR_CFG_A: rd_mux = ra;
            `PCS_ADR_CFG_B: rd_mux = rb;
            `PCS_ADR_RX_INJ: rd_mux = rl;
            `PCS_ADR_BUTTON: rd_mux = bt;
            default: rd_mux = 8'h00;
         endcase
      end
   endfunction

   wire set_latch;
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cst_r <= ST_CMD;
         csh_r <= 8'h00;
         cmd_r <= 8'h00;
         rd_sh_r <= 8'h00;
         ccnt_r <= 4'h0;
         wr_tx_inj <= 1'b0;
         power_down_out <= 1'b1;
         config_reg_a_out <= `PCS_RST_CFG_A;
         config_reg_b_out <= `PCS_RST_CFG_B;
         inj_tx_r <= 8'h00;
         inj_rx_r <= 8'h00;
         button_reg_r <= `PCS_RST_BUTTON;
         rx_path_out <= 8'h00;
         rx_path_inject_out <= 1'b0;
         ctrl_serial_out <= 1'b0;
         ctrl_serial_oe_out <= 1'b0;
      end else begin
         wr_tx_inj <= 1'b0;
         // latched flag: press sets, set wins over clear
         if (set_latch)
            button_reg_r[`PCS_BT_LATCHED] <= 1'b1;
         // receive path fed by injection or by pcm input
         rx_path_out <= rx_path_inject_out ? inj_rx_r : rx_last_r;
         // output released whenever select is high
         if (csn_s) begin
            ctrl_serial_oe_out <= 1'b0;
            ccnt_r <= 4'h0;
            if (cst_r == ST_RDATA)
               cst_r <= ST_CMD;
         end else begin
            if (ctrl_clk_rise) begin
               csh_r <= cbyte;
               if (ccnt_r == 4'h7) begin
                  ccnt_r <= 4'h0;
                  case (cst_r)
                     ST_CMD: begin
                        // power bit applied on every command
                        power_down_out <= cbyte[`PCS_CMD_POWER_BIT];
                        cmd_r <= cbyte;
                        // bit 1 more, bit 2 read
                        if (!cbyte[`PCS_CMD_MORE_BIT]) begin
                           cst_r <= ST_CMD;
                        end else if (cbyte[`PCS_CMD_READ_BIT]) begin
                           cst_r <= ST_RDATA;
                           rd_sh_r <= rd_mux(nadr, config_reg_a_out,
                              config_reg_b_out, rx_last_r, button_reg_r);
                        end else begin
                           cst_r <= ST_WDATA;
                        end
                     end
                     ST_WDATA: begin
                        cst_r <= ST_CMD;
                        case (cadr)
                           `PCS_ADR_CFG_A: config_reg_a_out <= cbyte;
                           `PCS_ADR_CFG_B: config_reg_b_out <= cbyte;
                           `PCS_ADR_RX_INJ: inj_rx_r <= cbyte;
                           `PCS_ADR_TX_INJ: begin
                              inj_tx_r <= cbyte;
                              wr_tx_inj <= 1'b1;
                           end
                           `PCS_ADR_BUTTON: begin
                              button_reg_r[7:5] <= cbyte[7:5];
                              if (!set_latch)
                                 button_reg_r[`PCS_BT_LATCHED] <= 1'b0;
                           end
                           default: ;
                        endcase
                        // receive-path source select lives in cfg b
                        if (cadr == `PCS_ADR_CFG_B)
                           rx_path_inject_out <= cbyte[`PCS_B_RX_SRC];
                     end
                     default: cst_r <= ST_CMD;
                  endcase
               end else begin
                  ccnt_r <= ccnt_r + 4'h1;
               end
            end
            // read data driven on falling control clock
            if (cst_r == ST_RDATA && ctrl_clk_fall) begin
               ctrl_serial_oe_out <= 1'b1;
               ctrl_serial_out <= rd_sh_r[7];
               rd_sh_r <= {rd_sh_r[6:0], 1'b0};
            end
         end
      end
   end

   // detector runs on its enable alone, power state ignored
   wire deb_level;
   wire bt_en = button_reg_r[`PCS_BT_ENABLE];
   pcs_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb (
      .clock_in(clock_in), .rst_in(rst_in), .run_in(bt_en),
      .level_in(btn_s), .level_out(deb_level));
   reg deb_d_r;
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in)
         deb_d_r <= 1'b1;
      else
         deb_d_r <= deb_level;
   end
   // low level means pressed
   assign set_latch = bt_en & ~deb_level & deb_d_r;
   wire pressed = button_reg_r[`PCS_BT_LATCH_MODE] ?
      button_reg_r[`PCS_BT_LATCHED] : ~deb_level;
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in)
         button_out <= 1'b0;
      else
         button_out <= bt_en & (pressed ^ button_reg_r[`PCS_BT_INVERT]);
   end
endmodule // pcs_port

// File: pcs_port_assertions.sv
// pcs_port_assertions.sv: port-level checks for pcs_port.
// assumes a 400 ns link clock, oversampled about 8x by clock_in.
module pcs_port_checker #(
   parameter DEB_CYCLES = 20
) (
   input logic clock_in,
   input logic rst_in,
   input logic link_clk_in,
   input logic pcm_tx_out,
   input logic pcm_tx_oe_out,
   input logic ctrl_sel_n_in,
   input logic ctrl_serial_oe_out,
   input logic power_down_out,
   input logic [7:0] config_reg_a_out,
   input logic [7:0] config_reg_b_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   sequence s_slot_on;
      pcm_tx_oe_out [*8];
   endsequence
   sequence s_slot_off;
      !pcm_tx_oe_out [*8];
   endsequence
   property p_slot_len;
      $rose(pcm_tx_oe_out) |-> s_slot_on;
   endproperty
   property p_slot_gap;
      $fell(pcm_tx_oe_out) |-> s_slot_off;
   endproperty
   // pin syncs put the link edge two or three cycles back
   property p_tx_edge;
      $changed(pcm_tx_out) && pcm_tx_oe_out && $past(pcm_tx_oe_out)
         |-> $past(link_clk_in, 2) !=
             (config_reg_b_out[7] && config_reg_b_out[6]);
   endproperty
   property p_aux_idle;
      config_reg_b_out[0] [*4] |-> !pcm_tx_oe_out;
   endproperty
   property p_en_gate;
      !config_reg_b_out[2] [*4] |-> !pcm_tx_oe_out;
   endproperty
   property p_pd_idle;
      power_down_out [*4] |-> !pcm_tx_oe_out;
   endproperty
   property p_co_float;
      ctrl_sel_n_in [*4] |-> !ctrl_serial_oe_out;
   endproperty
   property p_pd_load;
      $changed(power_down_out) |-> !$past(ctrl_sel_n_in, 3);
   endproperty
   property p_cfg_load;
      $changed(config_reg_a_out) || $changed(config_reg_b_out)
         |-> !$past(ctrl_sel_n_in, 3);
   endproperty
   a_slot_len: assert property (p_slot_len)
      else $error("tx slot shorter than one bit");
   a_slot_gap: assert property (p_slot_gap)
      else $error("tx driven right after its slot");
   a_tx_edge: assert property (p_tx_edge)
      else $error("tx shifted on the wrong link edge");
   a_aux_idle: assert property (p_aux_idle)
      else $error("tx driven with aux clock selected");
   a_en_gate: assert property (p_en_gate)
      else $error("tx driven with voice transfer off");
   a_pd_idle: assert property (p_pd_idle)
      else $error("tx driven while powered down");
   a_co_float: assert property (p_co_float)
      else $error("control output driven while deselected");
   a_pd_load: assert property (p_pd_load)
      else $error("power state changed outside a command");
   a_cfg_load: assert property (p_cfg_load)
      else $error("config changed outside a command");
endmodule // pcs_port_checker

// File: pcs_sync.v
// pcs_sync.v: two flip-flop synchroniser for asynchronous pin levels.
// assumes the destination domain is clock_in.
module pcs_sync (
   input wire clock_in,
   input wire rst_in,
   input wire d_in,
   output reg q_out
);
   reg meta_r;
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         meta_r <= 1'b0;
         q_out <= 1'b0;
      end else begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule // pcs_sync
